// ### hdl/prc_top.v
// peripheral reset control, pll input divider, adc prescaler and kernel clock selection
//
// Function
// - GPIO ports A..F held in reset while bits 17..22 are one.
// - Flexible communication module held in reset while bit 14 is one.
// - Checksum unit held in reset while bit 6 is one.
// - DMA request multiplexer held in reset while bit 3 is one.
// - DMA engine zero reset by bit 0, engine one by bit 1.
// - Crystal clock to PLL divided by 4-bit field bits 3:0 plus one.
// - ADC clock is AHB clock divided by field bits 31:27 plus two.
// - CAN1 clock from bits 15:14: crystal, APB2, APB2/2, internal 8 MHz.
// - CAN0 clock from bits 13:12 with the CAN1 encoding.
// - Serial2 clock from bits 7:6: crystal, system, low-speed crystal, internal.
// - Serial1 clock from bits 5:4 with the serial2 encoding.
// - Serial0 clock from bits 1:0 with the serial2 encoding.
// - Byte, half-word and word accesses are accepted.
// - Reset control register at offset 0x28, all zero after reset.
`timescale 1ns/1ps
`include "prc_defines.vh"

module prc_top #(
  parameter ADDR_W = `PRC_ADDR_W
) (
  // clock and reset (clock_i is the ahb bus clock)
  input  wire                        clock_i,
  input  wire                        arst_n_i,
  // register port
  input  wire                        reg_wr_i,
  input  wire                        reg_rd_i,
  input  wire [ADDR_W-1:0]           reg_addr_i,
  input  wire [3:0]                  reg_be_i,
  input  wire [31:0]                 reg_wdata_i,
  output reg  [31:0]                 reg_rdata_o,
  // source clocks from outside the domain
  input  wire                        high_speed_crystal_clock_i,
  input  wire                        second_apb_clock_i,
  input  wire                        internal_8mhz_osc_clock_i,
  input  wire                        low_speed_crystal_clock_i,
  input  wire                        system_clock_i,
  // peripheral reset holds
  output reg  [`PRC_PORT_COUNT-1:0]  port_hold_reset_o,
  output reg                         flex_comm_hold_reset_o,
  output reg                         checksum_unit_hold_reset_o,
  output reg                         dma_request_mux_hold_reset_o,
  output reg                         dma_engine_zero_hold_reset_o,
  output reg                         dma_engine_one_hold_reset_o,
  // derived clocks
  output reg                         pll_ref_clock_o,
  output reg                         adc_kernel_clock_o,
  output wire                        can_one_kernel_clock_o,
  output wire                        can_zero_kernel_clock_o,
  output wire                        serial_two_kernel_clock_o,
  output wire                        serial_one_kernel_clock_o,
  output wire                        serial_zero_kernel_clock_o
);

  // register storage
  reg  [31:0]                 rst_ctrl_q;
  reg  [31:0]                 pll_div_q;
  reg  [31:0]                 clk_sel_q;
  // source clock sampling
  wire [`PRC_SRC_COUNT-1:0]   src_raw;
  reg  [`PRC_SRC_COUNT-1:0]   src_s1_q;
  reg  [`PRC_SRC_COUNT-1:0]   src_s2_q;
  reg  [`PRC_SRC_COUNT-1:0]   src_s3_q;
  reg  [`PRC_SRC_COUNT-1:0]   src_lvl_q;
  reg  [`PRC_SRC_COUNT-1:0]   src_prev_q;
  reg                         apb2_half_q;
  // dividers
  reg  [`PRC_PLLDIV_W-1:0]    pll_cnt_q;
  wire [`PRC_PLLDIV_W-1:0]    pll_last;
  wire [`PRC_PLLDIV_W-1:0]    pll_half;
  reg  [`PRC_ADC_DIV_W-1:0]   adc_cnt_q;
  wire [`PRC_ADC_DIV_W-1:0]   adc_div;
  // switch inputs
  wire [3:0]                  can_src;
  wire [3:0]                  ser_src;

  // word match on the aligned offset; byte lanes are chosen by reg_be_i
  function hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] offset;
    begin
      hit = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
    end
  endfunction

  // merge enabled byte lanes, reserved bits stay at their reset value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0]  be;
    input [31:0] mask;
    integer      i;
    reg   [31:0] tmp;
    begin
      tmp = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          tmp[i*8 +: 8] = wdata[i*8 +: 8];
        end
      end
      merge = tmp & mask;
    end
  endfunction

  // register writes with byte, half-word or word lanes
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_ctrl_q <= `PRC_RESET_VALUE;
      pll_div_q  <= `PRC_RESET_VALUE;
      clk_sel_q  <= `PRC_RESET_VALUE;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, `PRC_OFS_RESET_CTRL)) begin
        rst_ctrl_q <= merge(rst_ctrl_q, reg_wdata_i, reg_be_i, `PRC_MASK_RESET_CTRL);
      end
      if (hit(reg_addr_i, `PRC_OFS_PLL_DIV)) begin
        pll_div_q <= merge(pll_div_q, reg_wdata_i, reg_be_i, `PRC_MASK_PLL_DIV);
      end
      if (hit(reg_addr_i, `PRC_OFS_CLK_SEL)) begin
        clk_sel_q <= merge(clk_sel_q, reg_wdata_i, reg_be_i, `PRC_MASK_CLK_SEL);
      end
    end
  end

  // read data, one cycle after the strobe; unmapped offsets read zero
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (hit(reg_addr_i, `PRC_OFS_RESET_CTRL)) begin
        reg_rdata_o <= rst_ctrl_q;
      end else if (hit(reg_addr_i, `PRC_OFS_PLL_DIV)) begin
        reg_rdata_o <= pll_div_q;
      end else if (hit(reg_addr_i, `PRC_OFS_CLK_SEL)) begin
        reg_rdata_o <= clk_sel_q;
      end else begin
        reg_rdata_o <= 32'h0000_0000;
      end
    end
  end

  // reset holds follow their control bits one cycle after the write
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_hold_reset_o            <= {`PRC_PORT_COUNT{1'b0}};
      flex_comm_hold_reset_o       <= 1'b0;
      checksum_unit_hold_reset_o   <= 1'b0;
      dma_request_mux_hold_reset_o <= 1'b0;
      dma_engine_zero_hold_reset_o <= 1'b0;
      dma_engine_one_hold_reset_o  <= 1'b0;
    end else begin
      port_hold_reset_o            <= rst_ctrl_q[`PRC_RST_PORT_MSB:`PRC_RST_PORT_LSB];
      flex_comm_hold_reset_o       <= rst_ctrl_q[`PRC_RST_FLEXCOMM_BIT];
      checksum_unit_hold_reset_o   <= rst_ctrl_q[`PRC_RST_CHECKSUM_BIT];
      dma_request_mux_hold_reset_o <= rst_ctrl_q[`PRC_RST_DMA_REQUEST_MUX_BIT];
      dma_engine_zero_hold_reset_o <= rst_ctrl_q[`PRC_RST_DMA0_BIT];
      dma_engine_one_hold_reset_o  <= rst_ctrl_q[`PRC_RST_DMA1_BIT];
    end
  end

  assign src_raw[`PRC_SRC_HXTAL] = high_speed_crystal_clock_i;
  assign src_raw[`PRC_SRC_APB2]  = second_apb_clock_i;
  assign src_raw[`PRC_SRC_IRC8M] = internal_8mhz_osc_clock_i;
  assign src_raw[`PRC_SRC_LXTAL] = low_speed_crystal_clock_i;
  assign src_raw[`PRC_SRC_SYS]   = system_clock_i;

  // three-stage sampling; a level counts only once stages two and three agree,
  // so sources must run at no more than a quarter of the bus clock to be reproduced faithfully
  genvar g;
  generate
    for (g = 0; g < `PRC_SRC_COUNT; g = g + 1) begin : g_sync
      always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          src_s1_q[g]   <= 1'b0;
          src_s2_q[g]   <= 1'b0;
          src_s3_q[g]   <= 1'b0;
          src_lvl_q[g]  <= 1'b0;
          src_prev_q[g] <= 1'b0;
        end else begin
          src_s1_q[g]   <= src_raw[g];
          src_s2_q[g]   <= src_s1_q[g];
          src_s3_q[g]   <= src_s2_q[g];
          src_prev_q[g] <= src_lvl_q[g];
          if (src_s2_q[g] == src_s3_q[g]) begin
            src_lvl_q[g] <= src_s3_q[g];
          end
        end
      end
    end
  endgenerate

  // apb2 halved by toggling on each sampled rising edge
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      apb2_half_q <= 1'b0;
    end else if (src_lvl_q[`PRC_SRC_APB2] && !src_prev_q[`PRC_SRC_APB2]) begin
      apb2_half_q <= ~apb2_half_q;
    end
  end

  // pll reference: crystal divided by field plus one, counted on crystal rising edges
  assign pll_last = pll_div_q[`PRC_PLLDIV_MSB:`PRC_PLLDIV_LSB];
  assign pll_half = (pll_last >> 1);

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pll_cnt_q       <= {`PRC_PLLDIV_W{1'b0}};
      pll_ref_clock_o <= 1'b0;
    end else begin
      if (src_lvl_q[`PRC_SRC_HXTAL] && !src_prev_q[`PRC_SRC_HXTAL]) begin
        pll_cnt_q <= (pll_cnt_q >= pll_last) ? {`PRC_PLLDIV_W{1'b0}} : pll_cnt_q + 1'b1;
      end
      if (pll_last == {`PRC_PLLDIV_W{1'b0}}) begin
        pll_ref_clock_o <= src_lvl_q[`PRC_SRC_HXTAL]; // undivided
      end else begin
        pll_ref_clock_o <= (pll_cnt_q <= pll_half);
      end
    end
  end

  // adc clock: bus clock divided by prescaler plus two, high for the first half
  assign adc_div = {1'b0, clk_sel_q[`PRC_ADC_CLOCK_PRESCALER_MSB:`PRC_ADC_CLOCK_PRESCALER_LSB]} + `PRC_ADC_DIV_OFFSET;

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adc_cnt_q          <= {`PRC_ADC_DIV_W{1'b0}};
      adc_kernel_clock_o <= 1'b0;
    end else begin
      adc_cnt_q          <= (adc_cnt_q >= adc_div - 1'b1) ? {`PRC_ADC_DIV_W{1'b0}} : adc_cnt_q + 1'b1;
      adc_kernel_clock_o <= (adc_cnt_q < (adc_div >> 1));
    end
  end

  // source sets in select-code order
  assign can_src = {src_lvl_q[`PRC_SRC_IRC8M], apb2_half_q,
                    src_lvl_q[`PRC_SRC_APB2], src_lvl_q[`PRC_SRC_HXTAL]};
  assign ser_src = {src_lvl_q[`PRC_SRC_IRC8M], src_lvl_q[`PRC_SRC_LXTAL],
                    src_lvl_q[`PRC_SRC_SYS], src_lvl_q[`PRC_SRC_HXTAL]};

  // one switch per CAN and serial kernel clock; each switch output is a flip-flop
  prc_clk_switch u_can_one (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .sel_i    (clk_sel_q[`PRC_CAN1_MSB:`PRC_CAN1_LSB]),
    .src_i    (can_src),
    .clk_o    (can_one_kernel_clock_o)
  );

  prc_clk_switch u_can_zero (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .sel_i    (clk_sel_q[`PRC_CAN0_MSB:`PRC_CAN0_LSB]),
    .src_i    (can_src),
    .clk_o    (can_zero_kernel_clock_o)
  );

  prc_clk_switch u_ser_two (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .sel_i    (clk_sel_q[`PRC_SER2_MSB:`PRC_SER2_LSB]),
    .src_i    (ser_src),
    .clk_o    (serial_two_kernel_clock_o)
  );

  prc_clk_switch u_ser_one (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .sel_i    (clk_sel_q[`PRC_SER1_MSB:`PRC_SER1_LSB]),
    .src_i    (ser_src),
    .clk_o    (serial_one_kernel_clock_o)
  );

  prc_clk_switch u_ser_zero (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .sel_i    (clk_sel_q[`PRC_SER0_MSB:`PRC_SER0_LSB]),
    .src_i    (ser_src),
    .clk_o    (serial_zero_kernel_clock_o)
  );

endmodule // prc_top

// ### hdl/prc_defines.vh
// register map, field layout, reset values and encodings of the reset and clock select slice
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH

// register byte offsets
`define PRC_OFS_RESET_CTRL    8'h28
`define PRC_OFS_PLL_DIV       8'h2c
`define PRC_OFS_CLK_SEL       8'h30
`define PRC_ADDR_W            8

// reset values and writable bit masks
`define PRC_RESET_VALUE       32'h0000_0000
`define PRC_MASK_RESET_CTRL   32'h007e_404b
`define PRC_MASK_PLL_DIV      32'h0000_000f
`define PRC_MASK_CLK_SEL      32'hf800_f0f3

// peripheral reset control fields
`define PRC_RST_DMA0_BIT      0
`define PRC_RST_DMA1_BIT      1
`define PRC_RST_DMA_REQUEST_MUX_BIT    3
`define PRC_RST_CHECKSUM_BIT  6
`define PRC_RST_FLEXCOMM_BIT  14
`define PRC_RST_PORT_LSB      17
`define PRC_RST_PORT_MSB      22
`define PRC_PORT_COUNT        6

// pll input divider field
`define PRC_PLLDIV_MSB        3
`define PRC_PLLDIV_LSB        0
`define PRC_PLLDIV_W          4

// clock select fields
`define PRC_ADC_CLOCK_PRESCALER_MSB        31
`define PRC_ADC_CLOCK_PRESCALER_LSB        27
`define PRC_ADC_CLOCK_PRESCALER_W          5
`define PRC_ADC_DIV_W         6
`define PRC_ADC_DIV_OFFSET    6'h02
`define PRC_CAN1_MSB          15
`define PRC_CAN1_LSB          14
`define PRC_CAN0_MSB          13
`define PRC_CAN0_LSB          12
`define PRC_SER2_MSB          7
`define PRC_SER2_LSB          6
`define PRC_SER1_MSB          5
`define PRC_SER1_LSB          4
`define PRC_SER0_MSB          1
`define PRC_SER0_LSB          0

// source clock indices after synchronisation
`define PRC_SRC_COUNT         5
`define PRC_SRC_HXTAL         0
`define PRC_SRC_APB2          1
`define PRC_SRC_IRC8M         2
`define PRC_SRC_LXTAL         3
`define PRC_SRC_SYS           4

// kernel clock switch phases
`define PRC_SW_RUN            2'h0
`define PRC_SW_DRAIN          2'h1
`define PRC_SW_ARM            2'h2

`endif

// ### hdl/prc_clk_switch.v
// glitch-free four-way kernel clock switch on sampled clock levels
`timescale 1ns/1ps
`include "prc_defines.vh"

module prc_clk_switch (
  // clock and reset
  input  wire       clock_i,
  input  wire       arst_n_i,
  // selection and sampled sources
  input  wire [1:0] sel_i,
  input  wire [3:0] src_i,
  // switched kernel clock
  output reg        clk_o
);

  localparam SW_RUN   = `PRC_SW_RUN;
  localparam SW_DRAIN = `PRC_SW_DRAIN;
  localparam SW_ARM   = `PRC_SW_ARM;

  reg [1:0] state_q;
  reg [1:0] cur_q;

  // the old source is only left on its low phase, the new one only joined on its low
  // phase, so no high pulse is ever cut short or stretched into a runt
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= SW_RUN;
      cur_q   <= 2'h0;
      clk_o   <= 1'b0;
    end else begin
      case (state_q)
        SW_RUN: begin
          clk_o <= src_i[cur_q];
          if (sel_i != cur_q) begin
            state_q <= SW_DRAIN;
          end
        end
        SW_DRAIN: begin
          if (!src_i[cur_q]) begin
            clk_o   <= 1'b0;
            cur_q   <= sel_i;
            state_q <= SW_ARM;
          end else begin
            clk_o <= src_i[cur_q]; // finish the running high phase
          end
        end
        SW_ARM: begin
          clk_o <= 1'b0;
          if (!src_i[cur_q]) begin
            state_q <= SW_RUN;
          end
        end
        default: begin
          state_q <= SW_RUN;
          clk_o   <= 1'b0;
        end
      endcase
    end
  end

endmodule // prc_clk_switch

// ### verification/prc_top_props.sv
// concurrent checks on the reset holds and the can one, serial two and serial zero kernel clock outputs of prc_top
`timescale 1ns/1ps
`include "prc_defines.vh"

module prc_props #(
  parameter ADDR_W = `PRC_ADDR_W
) (
  // clock and reset
  input logic                       clock_i,
  input logic                       arst_n_i,
  // register port
  input logic                       reg_wr_i,
  input logic [ADDR_W-1:0]          reg_addr_i,
  input logic [3:0]                 reg_be_i,
  input logic [31:0]                reg_wdata_i,
  // watched outputs
  input logic [`PRC_PORT_COUNT-1:0] port_hold_reset_o,
  input logic                       flex_comm_hold_reset_o,
  input logic                       checksum_unit_hold_reset_o,
  input logic                       dma_request_mux_hold_reset_o,
  input logic                       dma_engine_zero_hold_reset_o,
  input logic                       dma_engine_one_hold_reset_o,
  input logic                       can_one_kernel_clock_o,
  input logic                       serial_two_kernel_clock_o,
  input logic                       serial_zero_kernel_clock_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // a write to the reset control word; holds follow two edges later (register, then output flop)
  wire hit = reg_wr_i && ((reg_addr_i >> 2) == (`PRC_OFS_RESET_CTRL >> 2));

  chk_dma0_hold_follows: assert property (hit && reg_be_i[0] |-> ##2 dma_engine_zero_hold_reset_o == $past(reg_wdata_i[0], 2))
    else $error("dma engine zero hold does not follow its bit");
  chk_dma1_hold_follows: assert property (hit && reg_be_i[0] |-> ##2 dma_engine_one_hold_reset_o == $past(reg_wdata_i[1], 2))
    else $error("dma engine one hold does not follow its bit");
  chk_mux_hold_follows: assert property (hit && reg_be_i[0] |-> ##2 dma_request_mux_hold_reset_o == $past(reg_wdata_i[3], 2))
    else $error("dma request mux hold does not follow its bit");
  chk_crc_hold_follows: assert property (hit && reg_be_i[0] |-> ##2 checksum_unit_hold_reset_o == $past(reg_wdata_i[6], 2))
    else $error("checksum hold does not follow its bit");
  chk_flex_hold_follows: assert property (hit && reg_be_i[1] |-> ##2 flex_comm_hold_reset_o == $past(reg_wdata_i[14], 2))
    else $error("flex comm hold does not follow its bit");
  chk_port_holds_follow: assert property (hit && reg_be_i[2] |-> ##2 port_hold_reset_o == $past(reg_wdata_i[22:17], 2))
    else $error("port holds do not follow their bits");
  // without a write the port holds must stay put
  chk_port_holds_stay: assert property (!hit |-> ##2 $stable(port_hold_reset_o))
    else $error("port holds changed without a write");
  // no high pulse shorter than the fastest legal source allows
  chk_can_pulse_whole: assert property ($rose(can_one_kernel_clock_o) |-> can_one_kernel_clock_o[*2])
    else $error("can one kernel clock high pulse cut short");
  // a low phase is never cut short either, switching keeps it at two cycles or more
  chk_can_low_whole: assert property ($fell(can_one_kernel_clock_o) |-> !can_one_kernel_clock_o[*2])
    else $error("can one kernel clock low phase cut short");
  chk_ser2_pulse_whole: assert property ($rose(serial_two_kernel_clock_o) |-> serial_two_kernel_clock_o[*2])
    else $error("serial two kernel clock high pulse cut short");
  chk_ser0_pulse_whole: assert property ($rose(serial_zero_kernel_clock_o) |-> serial_zero_kernel_clock_o[*2])
    else $error("serial zero kernel clock high pulse cut short");
endmodule // prc_props

// ### verification/tb_prc_top.sv
// self-checking bench for the reset and clock select slice
`timescale 1ns/1ps
`include "prc_defines.vh"

module tb_prc_top;
  reg         clock_i     = 1'b0;
  reg         arst_n_i    = 1'b0;
  reg         reg_wr_i    = 1'b0;
  reg         reg_rd_i    = 1'b0;
  reg  [7:0]  reg_addr_i  = 8'h00;
  reg  [3:0]  reg_be_i    = 4'h0;
  reg  [31:0] reg_wdata_i = 32'h0000_0000;
  reg  [4:0]  src_q       = 5'h00;
  reg  [6:0]  prev_q      = 7'h00;
  wire [31:0] reg_rdata_o;
  wire [5:0]  port_o;
  wire [4:0]  one_o;
  wire [6:0]  clk_o;
  reg  [31:0] model [0:2];
  reg  [31:0] msk [0:2];
  integer     cp [0:3];
  integer     sp [0:3];
  integer     ec [0:6];
  integer     miscompares = 0;
  integer     compares    = 0;
  integer     cyc         = 0;
  integer     i, j, k, n, p;
  reg  [7:0]  a;
  reg  [3:0]  be;
  reg  [31:0] d;

  prc_top i_dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .high_speed_crystal_clock_i(src_q[4]), .second_apb_clock_i(src_q[3]), .internal_8mhz_osc_clock_i(src_q[2]),
    .low_speed_crystal_clock_i(src_q[1]), .system_clock_i(src_q[0]), .port_hold_reset_o(port_o),
    .flex_comm_hold_reset_o(one_o[4]), .checksum_unit_hold_reset_o(one_o[3]),
    .dma_request_mux_hold_reset_o(one_o[2]), .dma_engine_one_hold_reset_o(one_o[1]),
    .dma_engine_zero_hold_reset_o(one_o[0]), .pll_ref_clock_o(clk_o[6]), .adc_kernel_clock_o(clk_o[5]),
    .can_one_kernel_clock_o(clk_o[4]), .can_zero_kernel_clock_o(clk_o[3]), .serial_two_kernel_clock_o(clk_o[2]),
    .serial_one_kernel_clock_o(clk_o[1]), .serial_zero_kernel_clock_o(clk_o[0]));

  always #4 clock_i = ~clock_i;

  // sources of 8, 10, 12, 14, 18 cycles stay slower than a quarter of clock_i, so sampling keeps them whole
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    src_q <= {(cyc % 8) < 4, (cyc % 10) < 5, (cyc % 12) < 6, (cyc % 14) < 7, (cyc % 18) < 9};
    prev_q <= clk_o;
    for (j = 0; j < 7; j = j + 1) ec[j] <= ec[j] + (clk_o[j] & ~prev_q[j]);
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end

  task check(input string name, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected %0s: expected %h, seen %h", name, exp, got);
      end
    end
  endtask

  // edge counts over a window may differ by one from the ideal figure
  task near(input string name, input integer exp, input integer got);
    begin
      compares = compares + 1;
      if (got > exp + 1 || got + 1 < exp) begin
        miscompares = miscompares + 1;
        $display("unexpected %0s: expected %0d, seen %0d", name, exp, got);
      end
    end
  endtask

  // one-cycle write strobe; the model keeps only enabled lanes of writable bits
  task wr(input [7:0] wa, input [3:0] wb, input [31:0] wd);
    integer b;
    begin
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= wa;
      reg_be_i <= wb;
      reg_wdata_i <= wd;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      for (b = 0; b < 4; b = b + 1)
        if (wb[b]) model[(wa - 8'h28) / 4][b*8 +: 8] = wd[b*8 +: 8] & msk[(wa - 8'h28) / 4][b*8 +: 8];
    end
  endtask

  task rd(input [7:0] ra);
    reg [31:0] e;
    begin
      e = (ra >= 8'h28 && ra <= 8'h30) ? model[(ra - 8'h28) / 4] : 32'h0000_0000;
      @(posedge clock_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= ra;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      @(posedge clock_i);
      #1 check("read data", e, reg_rdata_o);
    end
  endtask

  task holds;
    begin
      repeat (3) @(posedge clock_i);
      #1 check("hold vector", {model[0][22:17], model[0][14], model[0][6], model[0][3], model[0][1], model[0][0]},
                {port_o, one_o});
    end
  endtask

  // settle long enough for a switch and for any divider count to wrap, then count edges
  task measure(input integer dn, input integer dp, input integer c);
    integer s [0:6];
    integer m;
    begin
      repeat (150) @(posedge clock_i);
      for (m = 0; m < 7; m = m + 1) s[m] = ec[m];
      repeat (720) @(posedge clock_i);
      near("pll ref edges", 720 / (8 * (dn + 1)), ec[6] - s[6]);
      near("adc edges", 720 / (dp + 2), ec[5] - s[5]);
      near("can one edges", 720 / cp[c], ec[4] - s[4]);
      near("can zero edges", 720 / cp[c], ec[3] - s[3]);
      near("serial two edges", 720 / sp[c], ec[2] - s[2]);
      near("serial one edges", 720 / sp[c], ec[1] - s[1]);
      near("serial zero edges", 720 / sp[c], ec[0] - s[0]);
    end
  endtask

  task close_out;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    void'($urandom(32'hb8a7));
    for (i = 0; i < 7; i = i + 1) ec[i] = 0;
    for (i = 0; i < 3; i = i + 1) model[i] = 32'h0000_0000;
    msk[0] = `PRC_MASK_RESET_CTRL;
    msk[1] = `PRC_MASK_PLL_DIV;
    msk[2] = `PRC_MASK_CLK_SEL;
    cp[0] = 8; cp[1] = 10; cp[2] = 20; cp[3] = 12;
    sp[0] = 8; sp[1] = 18; sp[2] = 14; sp[3] = 12;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    // reset values, then an unmapped slot that reads zero
    for (i = 0; i < 4; i = i + 1) rd(8'h28 + 4 * i);
    holds;
    wr(8'h28, 4'hf, 32'hffff_ffff & msk[0]);
    holds;
    wr(8'h28, 4'hf, 32'h0000_0000);
    holds;
    // random byte, half-word and word writes across the three words
    for (i = 0; i < 16; i = i + 1) begin
      k = $urandom % 3;
      a = 8'h28 + 4 * k;
      n = $urandom % 7;
      be = (n < 4) ? (4'h1 << n) : (n == 4) ? 4'h3 : (n == 5) ? 4'hc : 4'hf;
      d = $urandom & msk[k];
      if (d[31:27] == 5'h1f) d[31] = 1'b0;
      wr(a, be, d);
      rd(a);
      holds;
    end
    // every select code on all five muxes with a random divider and prescaler
    for (i = 0; i < 4; i = i + 1) begin
      n = $urandom % 16;
      p = $urandom % 31;
      wr(8'h2c, 4'hf, n);
      wr(8'h30, 4'hf, {p[4:0], 11'h000, i[1:0], i[1:0], 4'h0, i[1:0], i[1:0], 2'h0, i[1:0]});
      measure(n, p, i);
    end
    close_out;
  end
endmodule // tb_prc_top

bind prc_top prc_props #(.ADDR_W(ADDR_W)) i_props (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i),
  .reg_wdata_i(reg_wdata_i), .port_hold_reset_o(port_hold_reset_o), .flex_comm_hold_reset_o(flex_comm_hold_reset_o),
  .checksum_unit_hold_reset_o(checksum_unit_hold_reset_o),
  .dma_request_mux_hold_reset_o(dma_request_mux_hold_reset_o),
  .dma_engine_zero_hold_reset_o(dma_engine_zero_hold_reset_o),
  .dma_engine_one_hold_reset_o(dma_engine_one_hold_reset_o), .can_one_kernel_clock_o(can_one_kernel_clock_o),
  .serial_two_kernel_clock_o(serial_two_kernel_clock_o), .serial_zero_kernel_clock_o(serial_zero_kernel_clock_o));
